//--- rcch_pkg.sv
// Contract
// - config changes only while remote active
// - accepted settings saved to storage automatically
// - voltage regulator fast or slow, slow default
// - power-up restores last state or off; here always off, as the restore setting resets to off before its boot read
// - user text up to 40 characters stored
// - default monitor: voltage and active current
// - sink-only or source-only current routing
// - split routing and its swapped form
// - combined current around mid-scale zero
// - alarm pin: temperature only or power fail
// - alarm pin all: both alarms, default
// - settings kept per active user profile, user text shared by all
package rcch_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] RCCH_STATUS_OFF  = 8'h00;
  localparam logic [7:0] RCCH_AFTREM_OFF  = 8'h04;
  localparam logic [7:0] RCCH_VSPEED_OFF  = 8'h08;
  localparam logic [7:0] RCCH_CSPEED_OFF  = 8'h0c;
  localparam logic [7:0] RCCH_RESTORE_OFF = 8'h10;
  localparam logic [7:0] RCCH_MONITOR_OFF = 8'h14;
  localparam logic [7:0] RCCH_ALARM_OFF   = 8'h18;
  localparam logic [7:0] RCCH_TXTLEN_OFF  = 8'h1c;
  localparam logic [7:0] RCCH_IRQST_OFF   = 8'h20;
  localparam logic [7:0] RCCH_IRQMSK_OFF  = 8'h24;
  localparam logic [7:0] RCCH_TEXT_OFF    = 8'h40;
  // ==========================================================
  // sizes
  localparam int          RCCH_TEXT_CHARS = 40;
  localparam int          RCCH_TEXT_WORDS = 10;
  localparam int          RCCH_PROFILES   = 4;
  localparam logic [5:0]  RCCH_TEXT_MAX   = 6'h28;
  // ==========================================================
  // option encodings
  localparam logic        RCCH_KEEP_AUTO  = 1'b0;
  localparam logic        RCCH_KEEP_OFF   = 1'b1;
  localparam logic        RCCH_VREG_FAST  = 1'b0;
  localparam logic        RCCH_VREG_SLOW  = 1'b1;
  localparam logic [1:0]  RCCH_CS_FAST    = 2'h0;
  localparam logic [1:0]  RCCH_CS_SLOW    = 2'h1;
  localparam logic [1:0]  RCCH_CS_NORMAL  = 2'h2;
  localparam logic [2:0]  RCCH_MON_DEFAULT = 3'h0;
  localparam logic [2:0]  RCCH_MON_SINK    = 3'h1;
  localparam logic [2:0]  RCCH_MON_SOURCE  = 3'h2;
  localparam logic [2:0]  RCCH_MON_SPLIT   = 3'h3;
  localparam logic [2:0]  RCCH_MON_SPLITI  = 3'h4;
  localparam logic [2:0]  RCCH_MON_COMB    = 3'h5;
  localparam logic [1:0]  RCCH_AL_OT      = 2'h0;
  localparam logic [1:0]  RCCH_AL_PF      = 2'h1;
  localparam logic [1:0]  RCCH_AL_ALL     = 2'h2;
  // ==========================================================
  // reset values
  localparam logic        RCCH_AFTREM_RST  = 1'b0;
  localparam logic        RCCH_VSPEED_RST  = 1'b1;
  localparam logic [1:0]  RCCH_CSPEED_RST  = 2'h2;
  localparam logic        RCCH_RESTORE_RST = 1'b1;
  localparam logic [2:0]  RCCH_MONITOR_RST = 3'h0;
  localparam logic [1:0]  RCCH_ALARM_RST   = 2'h2;
  localparam logic [15:0] RCCH_MON_MID     = 16'h8000;
  // ==========================================================
  // interrupt bits
  localparam int          RCCH_IRQ_ACCEPT = 0;
  localparam int          RCCH_IRQ_REJECT = 1;
  localparam int          RCCH_IRQ_REMEND = 2;
  localparam int          RCCH_IRQ_W      = 3;
endpackage : rcch_pkg

//--- rcch_top.sv
`timescale 1ns/1ps
module rcch_top import rcch_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // device state, same clock domain
  input  wire logic        remote_active,
  input  wire logic [1:0]  profile_sel,
  input  wire logic        dc_on_req,
  input  wire logic        dc_off_req,
  input  wire logic        nv_last_dc_on,
  input  wire logic        sink_mode,
  input  wire logic [15:0] meas_voltage,
  input  wire logic [15:0] meas_src_current,
  input  wire logic [15:0] meas_sink_current,
  input  wire logic        overtemp_alarm,
  input  wire logic        power_fail_alarm,
  // outputs to power stage and analog pins
  output logic             dc_on,
  output logic             vreg_fast,
  output logic [1:0]       controller_speed_select,
  output logic [15:0]      voltage_monitor_output,
  output logic [15:0]      current_monitor_output,
  output logic             alarm_pin,
  // persistent storage write port
  output logic             nv_save_valid,
  output logic [1:0]       nv_save_profile,
  output logic [7:0]       nv_save_addr,
  output logic [31:0]      nv_save_data,
  output logic             irq
);

  // ==========================================================
  // settings storage, one set per user profile; user text and its length shared
  logic              aftrem_reg  [RCCH_PROFILES];
  logic              vspeed_reg  [RCCH_PROFILES];
  logic [1:0]        cspeed_reg  [RCCH_PROFILES];
  logic              restore_reg [RCCH_PROFILES];
  logic [2:0]        monitor_reg [RCCH_PROFILES];
  logic [1:0]        alarm_reg   [RCCH_PROFILES];
  logic [31:0]       text_mem    [RCCH_TEXT_WORDS];
  logic [5:0]        txtlen_reg;
  logic [RCCH_IRQ_W-1:0] irq_st_reg;
  logic [RCCH_IRQ_W-1:0] irq_msk_reg;
  logic              boot_done_reg;
  logic              remote_d_reg;
  logic              wr_access;
  logic              cfg_addr;
  logic              mapped;
  logic              opt_ok;
  logic              accept;
  logic              reject;
  logic              remote_end;
  logic              is_text;
  logic [3:0]        text_idx;
  logic [16:0]       comb_sum;

  // ==========================================================
  // apb decode; every access completes with no wait state
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign is_text   = (paddr >= RCCH_TEXT_OFF) && (paddr[1:0] == 2'h0)
                     && (paddr < RCCH_TEXT_OFF + 8'(4 * RCCH_TEXT_WORDS));
  assign text_idx  = 4'((paddr - RCCH_TEXT_OFF) >> 2);

  // configuration addresses: the ones that need remote control
  always_comb begin
    cfg_addr = is_text;
    case (paddr)
      RCCH_AFTREM_OFF, RCCH_VSPEED_OFF, RCCH_CSPEED_OFF, RCCH_RESTORE_OFF,
      RCCH_MONITOR_OFF, RCCH_ALARM_OFF, RCCH_TXTLEN_OFF: cfg_addr = 1'b1;
      default: ;
    endcase
  end

  assign mapped = cfg_addr || (paddr == RCCH_STATUS_OFF)
                  || (paddr == RCCH_IRQST_OFF) || (paddr == RCCH_IRQMSK_OFF);

  // option keyword check, unknown codes refused
  always_comb begin
    case (paddr)
      RCCH_CSPEED_OFF:  opt_ok = (pwdata[31:2] == 30'h0)
                                 && (pwdata[1:0] <= RCCH_CS_NORMAL);
      RCCH_MONITOR_OFF: opt_ok = (pwdata[31:3] == 29'h0)
                                 && (pwdata[2:0] <= RCCH_MON_COMB);
      RCCH_ALARM_OFF:   opt_ok = (pwdata[31:2] == 30'h0)
                                 && (pwdata[1:0] <= RCCH_AL_ALL);
      RCCH_TXTLEN_OFF:  opt_ok = (pwdata[31:6] == 26'h0)
                                 && (pwdata[5:0] <= RCCH_TEXT_MAX);
      RCCH_AFTREM_OFF, RCCH_VSPEED_OFF, RCCH_RESTORE_OFF:
                        opt_ok = (pwdata[31:1] == 31'h0);
      default:          opt_ok = 1'b1;
    endcase
  end

  // a config write lands only with remote on and a legal option
  assign accept  = wr_access && cfg_addr && remote_active && opt_ok;
  assign reject  = wr_access && cfg_addr && !(remote_active && opt_ok);
  assign pslverr = psel && penable && (!mapped || reject);

  // ==========================================================
  // per-profile settings; writes go to the active profile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < RCCH_PROFILES; i++) begin
        aftrem_reg[i]  <= RCCH_AFTREM_RST;
        vspeed_reg[i]  <= RCCH_VSPEED_RST;
        cspeed_reg[i]  <= RCCH_CSPEED_RST;
        restore_reg[i] <= RCCH_RESTORE_RST;
        monitor_reg[i] <= RCCH_MONITOR_RST;
        alarm_reg[i]   <= RCCH_ALARM_RST;
      end
    end else if (accept) begin
      case (paddr)
        RCCH_AFTREM_OFF:  aftrem_reg[profile_sel]  <= pwdata[0];
        RCCH_VSPEED_OFF:  vspeed_reg[profile_sel]  <= pwdata[0];
        RCCH_CSPEED_OFF:  cspeed_reg[profile_sel]  <= pwdata[1:0];
        RCCH_RESTORE_OFF: restore_reg[profile_sel] <= pwdata[0];
        RCCH_MONITOR_OFF: monitor_reg[profile_sel] <= pwdata[2:0];
        RCCH_ALARM_OFF:   alarm_reg[profile_sel]   <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // user text, shared by all profiles
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txtlen_reg <= 6'h00;
      for (int i = 0; i < RCCH_TEXT_WORDS; i++) begin
        text_mem[i] <= 32'h0;
      end
    end else if (accept) begin
      if (paddr == RCCH_TXTLEN_OFF) begin
        txtlen_reg <= pwdata[5:0];
      end
      if (is_text) begin
        text_mem[text_idx] <= pwdata;
      end
    end
  end

  // ==========================================================
  // every accepted change is pushed to storage, no save command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nv_save_valid   <= 1'b0;
      nv_save_profile <= 2'h0;
      nv_save_addr    <= 8'h00;
      nv_save_data    <= 32'h0;
    end else begin
      nv_save_valid <= accept;
      if (accept) begin
        nv_save_profile <= profile_sel;
        nv_save_addr    <= paddr;
        nv_save_data    <= pwdata;
      end
    end
  end

  // ==========================================================
  // dc terminal state: boot restore, remote exit, switch requests
  assign remote_end = remote_d_reg && !remote_active;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      remote_d_reg  <= 1'b0;
      boot_done_reg <= 1'b0;
      dc_on         <= 1'b0;
    end else begin
      remote_d_reg  <= remote_active;
      boot_done_reg <= 1'b1;
      if (!boot_done_reg) begin
        // strap read after release, never under reset
        dc_on <= (restore_reg[profile_sel] == RCCH_KEEP_AUTO)
                 && nv_last_dc_on;
      end else if (remote_end && aftrem_reg[profile_sel] == RCCH_KEEP_OFF) begin
        dc_on <= 1'b0;
      end else if (dc_off_req) begin
        dc_on <= 1'b0;
      end else if (dc_on_req) begin
        dc_on <= 1'b1;
      end
    end
  end

  // ==========================================================
  // regulator speed outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vreg_fast               <= 1'b0;
      controller_speed_select <= RCCH_CSPEED_RST;
    end else begin
      vreg_fast               <= (vspeed_reg[profile_sel] == RCCH_VREG_FAST);
      controller_speed_select <= cspeed_reg[profile_sel];
    end
  end

  // ==========================================================
  // monitor routing; combined mode halves both currents so the
  // sum fits, trading one bit of resolution for the shared range
  assign comb_sum = 17'(RCCH_MON_MID) + 17'(meas_src_current >> 1)
                    - 17'(meas_sink_current >> 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      voltage_monitor_output <= 16'h0000;
      current_monitor_output <= 16'h0000;
    end else begin
      case (monitor_reg[profile_sel])
        RCCH_MON_SINK: begin
          voltage_monitor_output <= meas_voltage;
          current_monitor_output <= meas_sink_current;
        end
        RCCH_MON_SOURCE: begin
          voltage_monitor_output <= meas_voltage;
          current_monitor_output <= meas_src_current;
        end
        RCCH_MON_SPLIT: begin
          voltage_monitor_output <= meas_sink_current;
          current_monitor_output <= meas_src_current;
        end
        RCCH_MON_SPLITI: begin
          voltage_monitor_output <= meas_src_current;
          current_monitor_output <= meas_sink_current;
        end
        RCCH_MON_COMB: begin
          voltage_monitor_output <= meas_voltage;
          current_monitor_output <= comb_sum[15:0];
        end
        default: begin
          voltage_monitor_output <= meas_voltage;
          current_monitor_output <= sink_mode ? meas_sink_current
                                              : meas_src_current;
        end
      endcase
    end
  end

  // ==========================================================
  // alarm pin selection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_pin <= 1'b0;
    end else begin
      case (alarm_reg[profile_sel])
        RCCH_AL_OT: alarm_pin <= overtemp_alarm;
        RCCH_AL_PF: alarm_pin <= power_fail_alarm;
        default:    alarm_pin <= overtemp_alarm || power_fail_alarm;
      endcase
    end
  end

  // ==========================================================
  // interrupts: sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_st_reg  <= '0;
      irq_msk_reg <= '0;
    end else begin
      irq_st_reg <= (irq_st_reg
                     & ~((wr_access && paddr == RCCH_IRQST_OFF)
                         ? pwdata[RCCH_IRQ_W-1:0] : '0))
                    | {remote_end, reject, accept};
      if (wr_access && paddr == RCCH_IRQMSK_OFF) begin
        irq_msk_reg <= pwdata[RCCH_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_st_reg & irq_msk_reg);

  // ==========================================================
  // read mux; reads never alter any setting
  always_comb begin
    prdata = 32'h0;
    if (is_text) begin
      prdata = text_mem[text_idx];
    end else begin
      case (paddr)
        RCCH_STATUS_OFF:  prdata = {28'h0, profile_sel, dc_on, remote_active};
        RCCH_AFTREM_OFF:  prdata = {31'h0, aftrem_reg[profile_sel]};
        RCCH_VSPEED_OFF:  prdata = {31'h0, vspeed_reg[profile_sel]};
        RCCH_CSPEED_OFF:  prdata = {30'h0, cspeed_reg[profile_sel]};
        RCCH_RESTORE_OFF: prdata = {31'h0, restore_reg[profile_sel]};
        RCCH_MONITOR_OFF: prdata = {29'h0, monitor_reg[profile_sel]};
        RCCH_ALARM_OFF:   prdata = {30'h0, alarm_reg[profile_sel]};
        RCCH_TXTLEN_OFF:  prdata = {26'h0, txtlen_reg};
        RCCH_IRQST_OFF:   prdata = {29'h0, irq_st_reg};
        RCCH_IRQMSK_OFF:  prdata = {29'h0, irq_msk_reg};
        default:          prdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // checks
  property p_no_change_without_remote;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_access && cfg_addr && !remote_active)
      |=> $changed(profile_sel) || ($stable(vspeed_reg[profile_sel])
                                    && $stable(alarm_reg[profile_sel]));
  endproperty
  a_no_change_without_remote: assert property (p_no_change_without_remote)
    else $error("setting changed with remote off");

  property p_save_follows;
    @(posedge sys_clk) disable iff (!rst_n)
    accept |=> nv_save_valid && nv_save_addr == $past(paddr)
               && nv_save_data == $past(pwdata);
  endproperty
  a_save_follows: assert property (p_save_follows)
    else $error("accepted write not saved");

  property p_remote_exit_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (boot_done_reg && remote_end && aftrem_reg[profile_sel] == RCCH_KEEP_OFF)
      |=> !dc_on;
  endproperty
  a_remote_exit_off: assert property (p_remote_exit_off)
    else $error("dc stayed on after remote exit");

  property p_boot_restore_off;
    @(posedge sys_clk)
    (rst_n && !boot_done_reg && restore_reg[profile_sel] == RCCH_KEEP_OFF)
      |=> !dc_on;
  endproperty
  a_boot_restore_off: assert property (p_boot_restore_off)
    else $error("dc on at boot with restore off");

  property p_split_route;
    @(posedge sys_clk) disable iff (!rst_n)
    (monitor_reg[profile_sel] == RCCH_MON_SPLIT)
      |=> voltage_monitor_output == $past(meas_sink_current);
  endproperty
  a_split_route: assert property (p_split_route)
    else $error("split routing wrong");

  property p_alarm_ot_only;
    @(posedge sys_clk) disable iff (!rst_n)
    (alarm_reg[profile_sel] == RCCH_AL_OT && !overtemp_alarm) |=> !alarm_pin;
  endproperty
  a_alarm_ot_only: assert property (p_alarm_ot_only)
    else $error("alarm pin not temperature only");

  property p_alarm_all;
    @(posedge sys_clk) disable iff (!rst_n)
    (alarm_reg[profile_sel] == RCCH_AL_ALL && power_fail_alarm) |=> alarm_pin;
  endproperty
  a_alarm_all: assert property (p_alarm_all)
    else $error("alarm all missed power fail");

  property p_reject_flags;
    @(posedge sys_clk) disable iff (!rst_n)
    reject |-> pslverr ##1 irq_st_reg[RCCH_IRQ_REJECT];
  endproperty
  a_reject_flags: assert property (p_reject_flags)
    else $error("rejected write not flagged");

endmodule : rcch_top

//--- rcch_stage_model.sv
`timescale 1ns/1ps
// ==========================================================
// power stage model
// readings come one edge late, as from a real converter
module rcch_stage_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] set_v,
  input  wire logic [15:0] set_src,
  input  wire logic [15:0] set_snk,
  output logic             [15:0] meas_voltage,
  output logic             [15:0] meas_src_current,
  output logic             [15:0] meas_sink_current
);
  // register every reading so the block never sees same-edge data
  always_ff @(posedge sys_clk) begin
    meas_voltage      <= set_v;
    meas_src_current  <= set_src;
    meas_sink_current <= set_snk;
  end
endmodule : rcch_stage_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench import rcch_pkg::*;;
  // ==========================================================
  // signals
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, nv_save_addr;
  logic [31:0] pwdata, prdata, nv_save_data, rd;
  logic        remote_active, dc_on_req, dc_off_req, nv_last_dc_on, sink_mode;
  logic        overtemp_alarm, power_fail_alarm, dc_on, vreg_fast, alarm_pin;
  logic        nv_save_valid, er;
  logic [1:0]  profile_sel, controller_speed_select, nv_save_profile;
  logic [15:0] meas_voltage, meas_src_current, meas_sink_current;
  logic [15:0] voltage_monitor_output, current_monitor_output;
  logic [15:0] set_v, set_src, set_snk;
  logic [31:0] mon_seen;
  int          failures, checks, saves, n0;
  rcch_top i_rcch_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .remote_active(remote_active), .profile_sel(profile_sel),
    .dc_on_req(dc_on_req), .dc_off_req(dc_off_req), .nv_last_dc_on(nv_last_dc_on),
    .sink_mode(sink_mode), .meas_voltage(meas_voltage),
    .meas_src_current(meas_src_current), .meas_sink_current(meas_sink_current),
    .overtemp_alarm(overtemp_alarm), .power_fail_alarm(power_fail_alarm), .dc_on(dc_on),
    .vreg_fast(vreg_fast), .controller_speed_select(controller_speed_select),
    .voltage_monitor_output(voltage_monitor_output),
    .current_monitor_output(current_monitor_output), .alarm_pin(alarm_pin),
    .nv_save_valid(nv_save_valid), .nv_save_profile(nv_save_profile),
    .nv_save_addr(nv_save_addr), .nv_save_data(nv_save_data), .irq(irq));
  rcch_stage_model i_rcch_stage_model (.sys_clk(sys_clk), .set_v(set_v),
    .set_src(set_src), .set_snk(set_snk), .meas_voltage(meas_voltage),
    .meas_src_current(meas_src_current), .meas_sink_current(meas_sink_current));
  // both monitor pins as one word, voltage pin in the upper half
  assign mon_seen = {voltage_monitor_output, current_monitor_output};
  // ==========================================================
  // clock and save pulse counter, sampled mid-cycle to avoid races
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (nv_save_valid === 1'b1) saves++;
  end
  // ==========================================================
  // tasks
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // one apb transfer; never assumes a slave latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    `CHK("write error flag", e, er)
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : idle
  // expected monitor pins {voltage, current} for a routing mode
  function automatic logic [31:0] mon_exp(input logic [2:0] m, input logic s);
    logic [15:0] v, c;
    v = set_v;
    c = s ? set_snk : set_src;
    case (m)
      RCCH_MON_SINK:   c = set_snk;
      RCCH_MON_SOURCE: c = set_src;
      RCCH_MON_SPLIT: begin
        v = set_snk;
        c = set_src;
      end
      RCCH_MON_SPLITI: begin
        v = set_src;
        c = set_snk;
      end
      RCCH_MON_COMB:   c = RCCH_MON_MID + (set_src >> 1) - (set_snk >> 1);
      default:         c = c;
    endcase
    return {v, c};
  endfunction : mon_exp
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, remote_active, dc_on_req, dc_off_req} = 7'h0;
    {sink_mode, overtemp_alarm, power_fail_alarm, paddr, pwdata} = 43'h0;
    {profile_sel, failures, checks, saves} = '0;
    nv_last_dc_on = 1'b1;
    set_v = 16'h1234;
    set_src = 16'h1000;
    set_snk = 16'h0400;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    idle(3);
    `CHK("dc_on boot", 1'b0, dc_on)
    `CHK("vreg rst", 1'b0, vreg_fast)
    `CHK("speed rst", RCCH_CS_NORMAL, controller_speed_select)
    rdc("restore rst", RCCH_RESTORE_OFF, 32'(RCCH_KEEP_OFF));
    rdc("alarm rst", RCCH_ALARM_OFF, 32'(RCCH_AL_ALL));
    // writes without remote control are refused, irq flags it
    wr(RCCH_VSPEED_OFF, 32'(RCCH_VREG_FAST), 1'b1);
    rdc("vspeed kept", RCCH_VSPEED_OFF, 32'(RCCH_VREG_SLOW));
    wr(RCCH_IRQMSK_OFF, 32'h7, 1'b0);
    idle(0);
    `CHK("irq reject", 1'b1, irq)
    wr(RCCH_IRQST_OFF, 32'h2, 1'b0);
    idle(0);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    @(posedge sys_clk);
    remote_active <= 1'b1;
    rdc("status", RCCH_STATUS_OFF, 32'h1);
    n0 = saves;
    wr(RCCH_VSPEED_OFF, 32'(RCCH_VREG_FAST), 1'b0);
    idle(2);
    `CHK("save count", n0 + 1, saves)
    `CHK("save addr", RCCH_VSPEED_OFF, nv_save_addr)
    `CHK("save data", 32'(RCCH_VREG_FAST), nv_save_data)
    `CHK("vreg fast", 1'b1, vreg_fast)
    n0 = saves;
    rdc("vspeed read", RCCH_VSPEED_OFF, 32'(RCCH_VREG_FAST));
    `CHK("read no save", n0, saves)
    // restore setting: legal keyword lands, stray upper bit refused
    wr(RCCH_RESTORE_OFF, 32'(RCCH_KEEP_AUTO), 1'b0);
    wr(RCCH_RESTORE_OFF, 32'h2, 1'b1);
    rdc("restore set", RCCH_RESTORE_OFF, 32'(RCCH_KEEP_AUTO));
    // every controller speed, then a bad code
    for (int i = 0; i < 3; i++) begin
      wr(RCCH_CSPEED_OFF, 32'(i), 1'b0);
      idle(2);
      `CHK("speed out", 2'(i), controller_speed_select)
    end
    wr(RCCH_CSPEED_OFF, 32'h3, 1'b1);
    rdc("speed kept", RCCH_CSPEED_OFF, 32'(RCCH_CS_NORMAL));
    // every monitor routing in both load directions
    for (int m = 0; m < 6; m++) begin
      wr(RCCH_MONITOR_OFF, 32'(m), 1'b0);
      for (int s = 0; s < 2; s++) begin
        @(posedge sys_clk);
        sink_mode <= s[0];
        idle(3);
        `CHK("monitor", mon_exp(3'(m), s[0]), mon_seen)
      end
    end
    wr(RCCH_MONITOR_OFF, 32'h6, 1'b1);
    // every alarm selection against all alarm combinations
    for (int a = 0; a < 3; a++) begin
      wr(RCCH_ALARM_OFF, 32'(a), 1'b0);
      for (int k = 0; k < 4; k++) begin
        @(posedge sys_clk);
        overtemp_alarm <= k[0];
        power_fail_alarm <= k[1];
        idle(2);
        `CHK("alarm", (a == 0) ? k[0] : (a == 1) ? k[1] : (k[0] | k[1]), alarm_pin)
      end
    end
    // user text, full length and one past it
    for (int i = 0; i < RCCH_TEXT_WORDS; i++) begin
      wr(8'(RCCH_TEXT_OFF + 4 * i), 32'h41424300 | i, 1'b0);
    end
    wr(RCCH_TXTLEN_OFF, 32'(RCCH_TEXT_CHARS), 1'b0);
    wr(RCCH_TXTLEN_OFF, 32'(RCCH_TEXT_CHARS + 1), 1'b1);
    rdc("text len", RCCH_TXTLEN_OFF, 32'(RCCH_TEXT_CHARS));
    for (int i = 0; i < RCCH_TEXT_WORDS; i++) begin
      rdc("text", 8'(RCCH_TEXT_OFF + 4 * i), 32'h41424300 | i);
    end
    // settings follow the active profile
    wr(RCCH_ALARM_OFF, 32'(RCCH_AL_OT), 1'b0);
    @(posedge sys_clk);
    profile_sel <= 2'h1;
    rdc("other profile", RCCH_ALARM_OFF, 32'(RCCH_AL_ALL));
    wr(RCCH_MONITOR_OFF, 32'(RCCH_MON_SINK), 1'b0);
    idle(0);
    `CHK("save profile", 2'h1, nv_save_profile)
    @(posedge sys_clk);
    profile_sel <= 2'h0;
    rdc("first profile", RCCH_ALARM_OFF, 32'(RCCH_AL_OT));
    // leaving remote with keep, then with switch-off
    @(posedge sys_clk);
    dc_on_req <= 1'b1;
    @(posedge sys_clk);
    dc_on_req <= 1'b0;
    remote_active <= 1'b0;
    idle(3);
    `CHK("dc kept", 1'b1, dc_on)
    apb(1'b0, RCCH_IRQST_OFF, 32'h0);
    `CHK("remote end flag", 1'b1, rd[RCCH_IRQ_REMEND])
    @(posedge sys_clk);
    remote_active <= 1'b1;
    wr(RCCH_AFTREM_OFF, 32'(RCCH_KEEP_OFF), 1'b0);
    @(posedge sys_clk);
    remote_active <= 1'b0;
    idle(3);
    `CHK("dc off", 1'b0, dc_on)
    summarize();
  end
endmodule : testbench
